// ===== logic/ssfl_link.sv
// slave frame link: switch capture, frame receive, reply, timers, ahb-lite registers
// Notes on behaviour
// - 8 data bits, 1 stop, no parity
// - eight rates from 9600 to 625000 bps
// - rate index from three switches, MSB third
// - every frame is exactly nine bytes
// - rotary 0..E is address, F uses parameter
// - protocol enabled by fourth function switch
// - switches sampled only after reset
// - axis parameter applied only after reset
// - one reply per addressed frame
// - broadcast acted on, never answered
// - group frame answered by group master only
// - alarm when no frame within receive period
// - any good check byte restarts period
// - response interval before reply starts
// - frame monitor expiry drops partial frame
// - header: reserved, sender, broadcast, address
// - rejected frame answers mode FFh
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module ssfl_link (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // serial line
   input wire logic rxd_i,
   output logic txd_o,
   output logic tx_en_o,
   // selectors and stored axis number
   input wire logic [3:0] address_rotary_selector_i,
   input wire logic [3:0] function_selector_bank_i,
   input wire logic [4:0] axis_param_i,
   // events
   output logic frame_valid_o,
   output logic comm_alarm_o
);
   import ssfl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [2:0] rxd_sync_reg;
   logic rxd_reg, rxd_next;
   logic [3:0] sa1_reg, sa2_reg, sa3_reg, sf1_reg, sf2_reg, sf3_reg;
   logic [3:0] cnt_up_reg, cnt_up_next;
   logic cfg_done_reg, cfg_done_next;
   logic [4:0] my_addr_reg, my_addr_next;
   logic [2:0] baud_reg, baud_next;
   logic proto_en_reg, proto_en_next;
   logic [12:0] div;

   always_comb begin
      rxd_next = (rxd_sync_reg[1] == rxd_sync_reg[2]) ? rxd_sync_reg[2] : rxd_reg;
      cnt_up_next = cnt_up_reg;
      cfg_done_next = cfg_done_reg;
      my_addr_next = my_addr_reg;
      baud_next = baud_reg;
      proto_en_next = proto_en_reg;
      if (!cfg_done_reg && sa2_reg == sa3_reg && sf2_reg == sf3_reg) begin
         cnt_up_next = cnt_up_reg + 4'h1;
         if (cnt_up_reg == 4'(STARTUP_CYC)) begin
            // captured once; later switch or parameter changes wait for reset
            cfg_done_next = 1'b1;
            my_addr_next = (sa3_reg == ADDR_SEL_PARAM) ? axis_param_i
                                                        : {1'b0, sa3_reg};
            baud_next = sf3_reg[2:0];
            proto_en_next = sf3_reg[3];
         end
      end else if (!cfg_done_reg) begin
         // a bouncing selector restarts the stability count
         cnt_up_next = 4'h0;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rxd_sync_reg <= 3'h7;
         rxd_reg <= 1'b1;
         sa1_reg <= 4'h0;
         sa2_reg <= 4'h0;
         sa3_reg <= 4'h0;
         sf1_reg <= 4'h0;
         sf2_reg <= 4'h0;
         sf3_reg <= 4'h0;
         cnt_up_reg <= 4'h0;
         cfg_done_reg <= 1'b0;
         my_addr_reg <= 5'h00;
         baud_reg <= 3'h0;
         proto_en_reg <= 1'b0;
      end else begin
         rxd_sync_reg <= {rxd_sync_reg[1:0], rxd_i};
         rxd_reg <= rxd_next;
         sa1_reg <= address_rotary_selector_i;
         sa2_reg <= sa1_reg;
         sa3_reg <= sa2_reg;
         sf1_reg <= function_selector_bank_i;
         sf2_reg <= sf1_reg;
         sf3_reg <= sf2_reg;
         cnt_up_reg <= cnt_up_next;
         cfg_done_reg <= cfg_done_next;
         my_addr_reg <= my_addr_next;
         baud_reg <= baud_next;
         proto_en_reg <= proto_en_next;
      end
   end

   assign div = baud_div(baud_reg);

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] rx_byte, tx_byte;
   logic rx_valid, tx_valid, tx_ready;

   ssfl_uart_rx u_rx (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .line_i(rxd_reg),
      .div_i(div),
      .byte_o(rx_byte),
      .valid_o(rx_valid)
   );

   ssfl_uart_tx u_tx (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .div_i(div),
      .data_i(tx_byte),
      .valid_i(tx_valid),
      .ready_o(tx_ready),
      .txd_o(txd_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   logic [15:0] ctrl_reg, ctrl_next, t1_reg, t1_next, t2_reg, t2_next, t3_reg, t3_next;
   logic [31:0] txd_reg, txd_next, rdata_reg, rdata_next;
   logic wr_pend_reg, wr_pend_next;
   logic [7:0] wa_reg, wa_next;
   logic alarm_reg, alarm_next, alarm_set;
   logic [7:0] buf_reg [0:FRAME_LEN-1];
   logic [7:0] buf_next [0:FRAME_LEN-1];
   logic [7:0] rbuf_reg [0:FRAME_LEN-1];
   logic [7:0] rbuf_next [0:FRAME_LEN-1];
   logic take;

   assign take = hsel_i && hready_i && htrans_i[1];

   always_comb begin
      ctrl_next = ctrl_reg;
      t1_next = t1_reg;
      t2_next = t2_reg;
      t3_next = t3_reg;
      txd_next = txd_reg;
      wr_pend_next = take && hwrite_i;
      wa_next = take ? haddr_i[7:0] : wa_reg;
      rdata_next = rdata_reg;
      alarm_next = alarm_reg;
      if (wr_pend_reg) begin
         case (wa_reg)
            OFS_CTRL: ctrl_next = hwdata_i[15:0];
            OFS_T1: t1_next = hwdata_i[15:0];
            OFS_T2: t2_next = hwdata_i[15:0];
            OFS_T3: t3_next = hwdata_i[15:0];
            OFS_TXD: txd_next = hwdata_i;
            OFS_STAT: alarm_next = alarm_reg && !hwdata_i[0];
            default: ;
         endcase
      end
      if (alarm_set) begin
         alarm_next = 1'b1; // set wins over clear
      end
      if (take && !hwrite_i) begin
         case (haddr_i[7:0])
            OFS_CTRL: rdata_next = {16'h0000, ctrl_reg};
            OFS_T1: rdata_next = {16'h0000, t1_reg};
            OFS_T2: rdata_next = {16'h0000, t2_reg};
            OFS_T3: rdata_next = {16'h0000, t3_reg};
            OFS_STAT: rdata_next = {16'h0000, 3'h0, my_addr_reg, 1'b0, baud_reg,
                                    1'b0, cfg_done_reg, proto_en_reg, alarm_reg};
            OFS_RXW0: rdata_next = {rbuf_reg[3], rbuf_reg[2], rbuf_reg[1], rbuf_reg[0]};
            OFS_RXW1: rdata_next = {rbuf_reg[7], rbuf_reg[6], rbuf_reg[5], rbuf_reg[4]};
            OFS_RXW2: rdata_next = {24'h000000, rbuf_reg[8]};
            OFS_TXD: rdata_next = txd_reg;
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_reg <= CTRL_RST;
         t1_reg <= T1_RST;
         t2_reg <= T2_RST;
         t3_reg <= T3_RST;
         txd_reg <= 32'h00000000;
         wr_pend_reg <= 1'b0;
         wa_reg <= 8'h00;
         rdata_reg <= 32'h00000000;
         alarm_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         t1_reg <= t1_next;
         t2_reg <= t2_next;
         t3_reg <= t3_next;
         txd_reg <= txd_next;
         wr_pend_reg <= wr_pend_next;
         wa_reg <= wa_next;
         rdata_reg <= rdata_next;
         alarm_reg <= alarm_next;
      end
   end

   assign hrdata_o = rdata_reg;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign comm_alarm_o = alarm_reg;

   ////////////////////////////////////////////////////////////////////////////
   ssfl_state_t state_reg, state_next;
   logic [3:0] idx_reg, idx_next;
   logic [7:0] bcc_reg, bcc_next;
   logic [5:0] us_reg, us_next;
   logic tick;
   logic [15:0] p1_reg, p1_next, tm_reg, tm_next;
   logic fv_reg, fv_next, good, nack, want_reply, grp_hit;
   ssfl_hdr_t hdr, rx_hdr;

   assign tick = (us_reg == 6'(US_CYC - 1));
   assign hdr = ssfl_hdr_t'(buf_reg[0]);
   assign rx_hdr = ssfl_hdr_t'(rx_byte);
   assign good = (state_reg == ST_COLLECT) && rx_valid && (idx_reg == 4'(FRAME_LEN - 1))
                 && (bcc_reg == rx_byte);
   assign nack = buf_reg[1][7];
   assign grp_hit = ctrl_reg[CTRL_GRP_EN] && hdr.addr == ctrl_reg[CTRL_GRP_LSB +: 5];
   // broadcast acts silently; group answers only from its master
   assign want_reply = !hdr.bcast && ((hdr.addr == my_addr_reg) ||
                       (grp_hit && ctrl_reg[CTRL_GRP_MST]));
   assign alarm_set = tick && (t1_reg != 16'h0000) && (p1_reg == t1_reg - 16'h0001);
   assign tx_valid = (state_reg == ST_SEND) && (idx_reg < 4'(FRAME_LEN));

   always_comb begin
      case (idx_reg)
         4'h0: tx_byte = {1'b0, 1'b0, 1'b0, my_addr_reg};
         4'h2: tx_byte = nack ? NACK_MODE : buf_reg[MODE_IDX];
         4'h4: tx_byte = txd_reg[7:0];
         4'h5: tx_byte = txd_reg[15:8];
         4'h6: tx_byte = txd_reg[23:16];
         4'h7: tx_byte = txd_reg[31:24];
         4'h8: tx_byte = bcc_reg;
         default: tx_byte = buf_reg[idx_reg];
      endcase
   end

   always_comb begin
      state_next = state_reg;
      idx_next = idx_reg;
      bcc_next = bcc_reg;
      us_next = tick ? 6'h00 : us_reg + 6'h01;
      tm_next = tick ? tm_reg + 16'h0001 : tm_reg;
      p1_next = (tick && p1_reg != t1_reg) ? p1_reg + 16'h0001 : p1_reg;
      fv_next = 1'b0;
      buf_next = buf_reg;
      rbuf_next = rbuf_reg;
      if (good) begin
         p1_next = 16'h0000;
      end
      case (state_reg)
         ST_HUNT: begin
            if (cfg_done_reg && proto_en_reg && rx_valid && !rx_hdr.rsvd
                && rx_hdr.sender) begin
               state_next = ST_COLLECT;
               buf_next[0] = rx_byte;
               bcc_next = rx_byte;
               idx_next = 4'h1;
               tm_next = 16'h0000;
            end
         end
         ST_COLLECT: begin
            if (rx_valid) begin
               buf_next[idx_reg] = rx_byte;
               bcc_next = bcc_reg ^ rx_byte;
               idx_next = idx_reg + 4'h1;
               if (idx_reg == 4'(FRAME_LEN - 1)) begin
                  state_next = ST_HUNT;
                  if (good && (hdr.bcast || grp_hit || hdr.addr == my_addr_reg)) begin
                     fv_next = 1'b1;
                     for (int i = 0; i < FRAME_LEN - 1; i++) begin
                        rbuf_next[i] = buf_reg[i];
                     end
                     rbuf_next[FRAME_LEN - 1] = rx_byte;
                     if (want_reply) begin
                        state_next = ST_DELAY;
                        tm_next = 16'h0000;
                        us_next = 6'h00;
                     end
                  end
               end
            end else if (t3_reg != 16'h0000 && tm_reg >= t3_reg) begin
               state_next = ST_HUNT;
            end
         end
         ST_DELAY: begin
            if (tm_reg >= t2_reg) begin
               state_next = ST_SEND;
               idx_next = 4'h0;
               bcc_next = 8'h00;
            end
         end
         ST_SEND: begin
            if (tx_valid && tx_ready) begin
               idx_next = idx_reg + 4'h1;
               bcc_next = bcc_reg ^ tx_byte;
            end else if (idx_reg == 4'(FRAME_LEN) && tx_ready) begin
               state_next = ST_HUNT;
            end
         end
         default: state_next = ST_HUNT;
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= ST_HUNT;
         idx_reg <= 4'h0;
         bcc_reg <= 8'h00;
         us_reg <= 6'h00;
         tm_reg <= 16'h0000;
         p1_reg <= 16'h0000;
         fv_reg <= 1'b0;
         for (int i = 0; i < FRAME_LEN; i++) begin
            buf_reg[i] <= 8'h00;
            rbuf_reg[i] <= 8'h00;
         end
      end else begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         bcc_reg <= bcc_next;
         us_reg <= us_next;
         tm_reg <= tm_next;
         p1_reg <= p1_next;
         fv_reg <= fv_next;
         buf_reg <= buf_next;
         rbuf_reg <= rbuf_next;
      end
   end

   assign tx_en_o = (state_reg == ST_SEND);
   assign frame_valid_o = fv_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   hdr_start_a: assert property ((state_reg == ST_HUNT) && cfg_done_reg && proto_en_reg
      && rx_valid && rx_byte[7:6] == 2'b01 |=> state_reg == ST_COLLECT)
      else $error("header not taken");
   bcast_silent_a: assert property (good && hdr.bcast |=> state_reg == ST_HUNT)
      else $error("broadcast answered");
   reply_len_a: assert property (state_reg == ST_SEND |-> idx_reg <= 4'h9)
      else $error("reply longer than a frame");
   t1_restart_a: assert property (good |=> p1_reg == 16'h0000)
      else $error("receive period not restarted");
   alarm_set_a: assert property (alarm_set |=> alarm_reg)
      else $error("timeout alarm not raised");
   t3_abort_a: assert property ((state_reg == ST_COLLECT) && !rx_valid && t3_reg != 0
      && tm_reg >= t3_reg |=> state_reg == ST_HUNT)
      else $error("partial frame kept");
   delay_hold_a: assert property ((state_reg == ST_DELAY) && tm_reg < t2_reg
      |=> state_reg != ST_SEND)
      else $error("reply started early");
   cfg_stable_a: assert property (cfg_done_reg |=> $stable(my_addr_reg)
      && $stable(baud_reg) && $stable(proto_en_reg))
      else $error("selector changed after capture");
   nack_byte_a: assert property (tx_valid && idx_reg == 4'h2 && nack
      |-> tx_byte == NACK_MODE)
      else $error("nack mode byte wrong");

   reply_c: cover property (state_reg == ST_SEND ##1 state_reg == ST_HUNT);
   bcast_c: cover property (good && hdr.bcast);
   alarm_c: cover property (alarm_set);
endmodule
`default_nettype wire

// ===== logic/ssfl_pkg.sv
// shared constants and types of the serial slave frame link
package ssfl_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_NS = 20;
   localparam int US_NS = 1000;
   localparam int US_CYC = US_NS / CLK_NS;
   localparam int STARTUP_CYC = 8;
   localparam int FRAME_LEN = 9;
   localparam int MODE_IDX = 2;
   localparam logic [3:0] ADDR_SEL_PARAM = 4'hf;
   localparam logic [7:0] NACK_MODE = 8'hff;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_T1 = 8'h04;
   localparam logic [7:0] OFS_T2 = 8'h08;
   localparam logic [7:0] OFS_T3 = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_RXW0 = 8'h14;
   localparam logic [7:0] OFS_RXW1 = 8'h18;
   localparam logic [7:0] OFS_RXW2 = 8'h1c;
   localparam logic [7:0] OFS_TXD = 8'h20;
   // reset values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] T1_RST = 16'h0000;
   localparam logic [15:0] T2_RST = 16'h0000;
   localparam logic [15:0] T3_RST = 16'h0000;
   // ctrl fields
   localparam int CTRL_GRP_EN = 0;
   localparam int CTRL_GRP_MST = 1;
   localparam int CTRL_GRP_LSB = 8;

   typedef struct packed {
      logic rsvd;
      logic sender;
      logic bcast;
      logic [4:0] addr;
   } ssfl_hdr_t;

   typedef enum logic [1:0] {
      ST_HUNT = 2'b00,
      ST_COLLECT = 2'b01,
      ST_DELAY = 2'b11,
      ST_SEND = 2'b10
   } ssfl_state_t;

   // cycles per bit for the eight selectable rates
   function automatic logic [12:0] baud_div(input logic [2:0] idx);
      case (idx)
         3'h0: baud_div = 13'(CLK_HZ / 9600);
         3'h1: baud_div = 13'(CLK_HZ / 19200);
         3'h2: baud_div = 13'(CLK_HZ / 38400);
         3'h3: baud_div = 13'(CLK_HZ / 57600);
         3'h4: baud_div = 13'(CLK_HZ / 115200);
         3'h5: baud_div = 13'(CLK_HZ / 250000);
         3'h6: baud_div = 13'(CLK_HZ / 312500);
         default: baud_div = 13'(CLK_HZ / 625000);
      endcase
   endfunction
endpackage

// ===== logic/ssfl_uart_rx.sv
// character receiver: start, 8 data bits lsb first, 1 stop bit, no parity
`timescale 1ns/1ns
`default_nettype none
module ssfl_uart_rx (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // line and rate
   input wire logic line_i,
   input wire logic [12:0] div_i,
   // received character
   output logic [7:0] byte_o,
   output logic valid_o
);
   logic busy_reg, busy_next, valid_reg, valid_next;
   logic [12:0] cnt_reg, cnt_next;
   logic [3:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next, byte_reg, byte_next;

   always_comb begin
      busy_next = busy_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      byte_next = byte_reg;
      valid_next = 1'b0;
      if (!busy_reg) begin
         if (!line_i) begin
            busy_next = 1'b1;
            cnt_next = div_i >> 1;
            bit_next = 4'h0;
         end
      end else if (cnt_reg != 13'h0000) begin
         cnt_next = cnt_reg - 13'h0001;
      end else begin
         cnt_next = div_i - 13'h0001;
         if (bit_reg == 4'h0) begin
            busy_next = !line_i;
            bit_next = 4'h1;
         end else if (bit_reg <= 4'h8) begin
            sh_next = {line_i, sh_reg[7:1]};
            bit_next = bit_reg + 4'h1;
         end else begin
            // a missing stop bit drops the character
            busy_next = 1'b0;
            if (line_i) begin
               valid_next = 1'b1;
               byte_next = sh_reg;
            end
         end
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_reg <= 1'b0;
         cnt_reg <= 13'h0000;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         byte_reg <= 8'h00;
         valid_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         byte_reg <= byte_next;
         valid_reg <= valid_next;
      end
   end

   assign byte_o = byte_reg;
   assign valid_o = valid_reg;
endmodule
`default_nettype wire

// ===== logic/ssfl_uart_tx.sv
// character transmitter: start, 8 data bits lsb first, 1 stop bit
`timescale 1ns/1ns
`default_nettype none
module ssfl_uart_tx (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // rate and character
   input wire logic [12:0] div_i,
   input wire logic [7:0] data_i,
   input wire logic valid_i,
   output logic ready_o,
   // line
   output logic txd_o
);
   logic [9:0] sh_reg, sh_next;
   logic [3:0] bits_reg, bits_next;
   logic [12:0] cnt_reg, cnt_next;

   always_comb begin
      sh_next = sh_reg;
      bits_next = bits_reg;
      cnt_next = cnt_reg;
      if (bits_reg == 4'h0) begin
         if (valid_i) begin
            sh_next = {1'b1, data_i, 1'b0};
            bits_next = 4'ha;
            cnt_next = div_i - 13'h0001;
         end
      end else if (cnt_reg != 13'h0000) begin
         cnt_next = cnt_reg - 13'h0001;
      end else begin
         sh_next = {1'b1, sh_reg[9:1]};
         bits_next = bits_reg - 4'h1;
         cnt_next = div_i - 13'h0001;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sh_reg <= 10'h3ff;
         bits_reg <= 4'h0;
         cnt_reg <= 13'h0000;
      end else begin
         sh_reg <= sh_next;
         bits_reg <= bits_next;
         cnt_reg <= cnt_next;
      end
   end

   assign ready_o = (bits_reg == 4'h0);
   assign txd_o = sh_reg[0];
endmodule
`default_nettype wire

// ===== tb/ssfl_master_model.sv
// master controller model: sends frames on the line, captures replies
`timescale 1ns/1ns
`default_nettype none
module ssfl_master_model #(
   parameter int DIV = 80,
   parameter int GAP = 25000
) (
   // clock
   input wire logic mclk_i,
   // slave reply side
   input wire logic txd_i,
   input wire logic tx_en_i,
   // master send side
   output logic line_o
);
   logic [7:0] got_q[$];
   // line rests at the bias level between frames
   initial line_o = 1'b1;
   task automatic put_byte(input logic [7:0] b);
      logic [9:0] sh;
      sh = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_o <= sh[i];
         repeat (DIV) @(posedge mclk_i);
      end
   endtask
   task automatic put_frame(input logic [7:0] f [9]);
      repeat (f[0][5] ? 10 * GAP : GAP) @(posedge mclk_i);
      for (int i = 0; i < 9; i++) begin
         put_byte(f[i]);
      end
   endtask
   always @(negedge txd_i) begin : cap
      logic [7:0] b;
      if (tx_en_i === 1'b1) begin
         repeat (DIV / 2) @(posedge mclk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge mclk_i);
            b[i] = txd_i;
         end
         repeat (DIV) @(posedge mclk_i);
         if (txd_i === 1'b1) got_q.push_back(b);
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench: register access and frame traffic
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ssfl_pkg::*;
   logic mclk_i, reset_i, hsel_i, hwrite_i, hready_i, rxd_i;
   logic hreadyout_o, hresp_o, txd_o, tx_en_o, frame_valid_o, comm_alarm_o;
   logic [31:0] haddr_i, hwdata_i, hrdata_o;
   logic [1:0] htrans_i;
   logic [2:0] hsize_i;
   logic [3:0] rot, fsel;
   logic [4:0] axis;
   int bad_count, n_checks, fv_n, cyc;
   assign hready_i = hreadyout_o;
   assign hsize_i = 3'h2;
   // one driver on the segment, so its address is unique
   ssfl_link ssfl_link_inst (.mclk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .rxd_i, .txd_o,
      .tx_en_o, .address_rotary_selector_i(rot), .function_selector_bank_i(fsel),
      .axis_param_i(axis), .frame_valid_o, .comm_alarm_o);
   ssfl_master_model #(.DIV(CLK_HZ / 625000), .GAP(200)) ssfl_master_model_inst (
      .mclk_i, .txd_i(txd_o), .tx_en_i(tx_en_o), .line_o(rxd_i));
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc++;
      if (frame_valid_o === 1'b1) fv_n++;
      if (cyc == 99000) begin
         bad_count++;
         finish_test();
      end
   end
   ////////////////////////////////////////
   task automatic finish_test();
      $display("checks=%0d bad=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {24'h0, a};
      hwrite_i <= wr;
      @(posedge mclk_i);
      while (hreadyout_o !== 1'b1) @(posedge mclk_i);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      @(posedge mclk_i);
      while (hreadyout_o !== 1'b1) @(posedge mclk_i);
      rd = hrdata_o;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      chk(x, e);
      chk(32'(hresp_o), 32'h0);
   endtask
   task automatic do_reset();
      reset_i <= 1'b1;
      repeat (20) @(posedge mclk_i);
      reset_i <= 1'b0;
      repeat (20) @(posedge mclk_i);
   endtask
   task automatic tend(input string s);
      $display("test %s done", s);
   endtask
   function automatic logic [7:0] bcc(input logic [7:0] f [9]);
      bcc = 8'h00;
      for (int i = 0; i < 8; i++) bcc ^= f[i];
   endfunction
   // one frame from the master, then the reply (or its absence) is judged
   task automatic xfer(input logic [7:0] h, a, input logic rep, input int nfv);
      logic [7:0] f [9];
      logic [7:0] q [9];
      int n;
      f = '{h, a, 8'h05, 8'h21, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00};
      f[8] = bcc(f);
      q = '{8'h03, a, a[7] ? 8'hff : 8'h05, 8'h21, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00};
      q[8] = bcc(q);
      fv_n = 0;
      n = 0;
      ssfl_master_model_inst.got_q.delete();
      ssfl_master_model_inst.put_frame(f);
      while (tx_en_o !== 1'b1 && n < 2000) begin
         @(posedge mclk_i);
         n++;
      end
      if (nfv >= 0) chk(32'(fv_n), 32'(nfv));
      chk(32'(n < 2000), 32'(rep));
      if (rep) begin
         chk(32'(n > 900 && n < 1010), 32'h1);
         while (tx_en_o === 1'b1) @(posedge mclk_i);
         chk(32'(ssfl_master_model_inst.got_q.size()), 32'h9);
         foreach (q[i]) chk(32'(ssfl_master_model_inst.got_q[i]), 32'(q[i]));
      end
   endtask
   ////////////////////////////////////////
   initial begin
      reset_i = 1'b1;
      hsel_i = 1'b0;
      hwrite_i = 1'b0;
      haddr_i = 32'h0;
      hwdata_i = 32'h0;
      htrans_i = 2'h0;
      rot = 4'h3;
      fsel = 4'hf;
      axis = 5'h0a;
      do_reset();
      rdc(OFS_STAT, 32'h0000_0376);
      rdc(OFS_CTRL, 32'h0);
      rdc(OFS_T1, 32'h0);
      rdc(OFS_T3, 32'h0);
      rdc(8'h40, 32'h0);
      tend("regs");
      wr(OFS_T2, 32'd20);
      wr(OFS_TXD, 32'h4433_2211);
      xfer(8'h43, 8'h40, 1'b1, 1);
      rdc(OFS_RXW0, 32'h2105_4043);
      xfer(8'h60, 8'h40, 1'b0, 1);
      wr(OFS_CTRL, 32'h0000_0903);
      xfer(8'h49, 8'h40, 1'b1, 1);
      wr(OFS_CTRL, 32'h0000_0901);
      xfer(8'h49, 8'h40, 1'b0, 1);
      tend("frames");
      wr(OFS_T1, 32'd160);
      xfer(8'h44, 8'h40, 1'b0, 0);
      wr(OFS_STAT, 32'h1);
      repeat (4000) @(posedge mclk_i);
      chk(32'(comm_alarm_o), 32'h0);
      repeat (3000) @(posedge mclk_i);
      chk(32'(comm_alarm_o), 32'h1);
      wr(OFS_T1, 32'h0);
      wr(OFS_STAT, 32'h1);
      @(posedge mclk_i);
      chk(32'(comm_alarm_o), 32'h0);
      tend("period");
      wr(OFS_T3, 32'd200);
      ssfl_master_model_inst.put_byte(8'h43);
      ssfl_master_model_inst.put_byte(8'h40);
      repeat (9500) @(posedge mclk_i);
      xfer(8'h43, 8'hc0, 1'b1, 1);
      tend("monitor");
      rot <= 4'hf;
      fsel <= 4'h5;
      rdc(OFS_STAT, 32'h0000_0376);
      do_reset();
      rdc(OFS_STAT, 32'h0000_0a54);
      axis <= 5'h0c;
      rdc(OFS_STAT, 32'h0000_0a54);
      tend("switches");
      finish_test();
   end
endmodule
`default_nettype wire
